// File: design/cfsc_defs.svh
// Register offsets, field positions, reset values and limits of the CAN filter/irq/sleep control block
`ifndef CFSC_DEFS_SVH
`define CFSC_DEFS_SVH
`define CFSC_OFF_CTRL0    8'h00
`define CFSC_OFF_CTRL1    8'h04
`define CFSC_OFF_BT0      8'h08
`define CFSC_OFF_BT1      8'h0c
`define CFSC_OFF_RFLG     8'h10
`define CFSC_OFF_RIER     8'h14
`define CFSC_OFF_TFLG     8'h18
`define CFSC_OFF_TIER     8'h1c
`define CFSC_OFF_ACC      8'h20
`define CFSC_OFF_ERRCNT   8'h24
`define CFSC_OFF_FILT     8'h30
`define CFSC_FILT_MASK    8'hf0
`define CFSC_C0_SOFT      0
`define CFSC_C0_SLEEP_REQUEST_BIT     1
`define CFSC_C0_WSTOP     2
`define CFSC_C0_SLEEP_ACK_FLAG     3
`define CFSC_C0_BUSY      4
`define CFSC_F_WUP        7
`define CFSC_F_RWRN       6
`define CFSC_F_TWRN       5
`define CFSC_F_RERR       4
`define CFSC_F_TERR       3
`define CFSC_F_BOFF       2
`define CFSC_F_OVR        1
`define CFSC_F_RXF        0
`define CFSC_AC_MODE_HI   5
`define CFSC_AC_MODE_LO   4
`define CFSC_RST_TXE      3'h7
`define CFSC_RST_SOFT     1'h1
`define CFSC_WARN_LIM     9'h060
`define CFSC_PASS_LIM     9'h07f
`define CFSC_BOFF_LIM     9'h0ff
`define CFSC_RUN_BITS     4'hb
`define CFSC_BOFF_GROUPS  8'h80
`define CFSC_RESP_OKAY    2'h0
`define CFSC_RESP_DECERR  2'h3
`endif

// File: design/cfsc_pkg.sv
// Types shared by the CAN filter/irq/sleep control block
package cfsc_pkg;
	typedef enum logic [1:0] {
		FM_32 = 2'b00, FM_16 = 2'b01, FM_8 = 2'b10, FM_CLOSED = 2'b11
	} cfsc_fmode_e;
	typedef enum logic [1:0] {
		MD_NORMAL = 2'b00, MD_SLEEP = 2'b01, MD_SOFT = 2'b10, MD_PDOWN = 2'b11
	} cfsc_mode_e;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00, ST_WAIT = 2'b01, ST_SLEEP = 2'b10, ST_RESYNC = 2'b11
	} cfsc_state_e;
endpackage : cfsc_pkg

// File: design/cfsc_mem_if.sv
// Carrier between the control block and its filter word store
`timescale 1ns/1ps
interface cfsc_mem_if #(parameter int DEPTH = 4, parameter int W = 32);
	logic                     we;
	logic [$clog2(DEPTH)-1:0] waddr;
	logic [W-1:0]             wdata;
	logic [W/8-1:0]           wstrb;
	logic [DEPTH*W-1:0]       words;
	modport ctl (output we, waddr, wdata, wstrb, input words);
	modport mem (input we, waddr, wdata, wstrb, output words);
endinterface : cfsc_mem_if

// File: design/cfsc_regmem.sv
// Acceptance pattern and mask word store, byte-writable, contents held in flops
`timescale 1ns/1ps
module cfsc_regmem #(
	parameter int DEPTH = 4,
	parameter int W     = 32
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Store port
	cfsc_mem_if.mem  m
);
	import cfsc_pkg::*;
	logic [W-1:0] mem_q [DEPTH];

	genvar g, b;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_word
			for (b = 0; b < W/8; b++) begin : g_byte
				always_ff @(posedge aclk) begin
					if (!aresetn) begin
						mem_q[g][8*b +: 8] <= 8'h00;
					end else if (m.we && m.waddr == g && m.wstrb[b]) begin
						mem_q[g][8*b +: 8] <= m.wdata[8*b +: 8];
					end
				end
			end
			assign m.words[W*g +: W] = mem_q[g];
		end
	endgenerate
endmodule : cfsc_regmem

// File: design/cfsc_top.sv
// CAN acceptance filter, interrupt flags, configuration lock and low-power mode control
// Function
// - Masked compare of received identifier against pattern
// - Accept sets full flag, lowest filter index
// - 32-bit mode: two full filters, hits 0-1
// - 16-bit mode: four filters, hits 0-3
// - 8-bit mode: eight byte filters, hits 0-7
// - Closed mode never fills foreground buffer
// - Four interrupt outputs from eleven enabled flags
// - Transmit interrupt on enabled empty buffer
// - Full flag and receive interrupt after frame end
// - Wakeup flag set only while asleep and enabled
// - Warning flags when counters reach 96
// - Passive flags when counters exceed 127
// - Bus-off flag when transmit counter exceeds 255
// - Write-one clears flags, ignored while condition holds
// - Error counters are never software writable
// - Configuration writable only during soft reset
// - Transmit output recessive in stop mode
// - Mode from stop, wait, sleep, soft-reset
// - Sleep only after pending traffic finishes
// - Sleep halts traffic, copies, bus-off counting
// - Wake on activity, request clear, soft reset
// - Eleven recessive bits before rejoining after wake
// - Third accepted message discarded, overrun flagged
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "cfsc_defs.svh"
module cfsc_top #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Protocol engine status
	input  wire logic              bit_tick,
	input  wire logic              core_tx,
	input  wire logic              rx_eof,
	input  wire logic [28:0]       rx_id,
	input  wire logic              rx_ide,
	input  wire logic              rx_rtr,
	input  wire logic              rx_srr,
	input  wire logic              rx_busy,
	input  wire logic [2:0]        tx_done,
	input  wire logic [8:0]        rec_cnt,
	input  wire logic [8:0]        tec_cnt,
	// CPU low-power state
	input  wire logic              cpu_stop,
	input  wire logic              cpu_wait,
	// CAN pins
	input  wire logic              can_rx,
	output logic                   can_tx_out,
	// Interrupts
	output logic                   irq_wakeup,
	output logic                   irq_error,
	output logic                   irq_rx,
	output logic                   irq_tx,
	// Engine control
	output logic                   fg_load,
	output logic [2:0]             filter_hit_index,
	output logic [2:0]             tx_empty_flag,
	output logic                   tx_enable,
	output logic                   busoff_done,
	output cfsc_pkg::cfsc_mode_e   mode
);
	import cfsc_pkg::*;

	function automatic logic meq(input logic [31:0] a, input logic [31:0] p, input logic [31:0] m);
		meq = ((a ^ p) & ~m) == 32'h0;
	endfunction : meq

	function automatic logic [2:0] first_hit(input logic [7:0] h);
		first_hit = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (h[i]) begin
				first_hit = 3'(i);
			end
		end
	endfunction : first_hit

	function automatic logic is_lock(input logic [7:0] a);
		is_lock = a == `CFSC_OFF_CTRL1 || a == `CFSC_OFF_BT0 || a == `CFSC_OFF_BT1 || a == `CFSC_OFF_ACC;
	endfunction : is_lock

	function automatic logic is_known(input logic [7:0] a);
		is_known = is_lock(a) || a == `CFSC_OFF_CTRL0 || a == `CFSC_OFF_RFLG || a == `CFSC_OFF_RIER ||
			a == `CFSC_OFF_TFLG || a == `CFSC_OFF_TIER || a == `CFSC_OFF_ERRCNT ||
			(a & `CFSC_FILT_MASK) == `CFSC_OFF_FILT;
	endfunction : is_known

	cfsc_mem_if #(.DEPTH(4), .W(32)) mif ();
	cfsc_regmem #(.DEPTH(4), .W(32)) u_mem (.aclk(aclk), .aresetn(aresetn), .m(mif.mem));

	// Registers
	logic        soft_q, sleep_request_bit_q, wstop_q;
	logic [7:0]  ctrl1_q, bt0_q, bt1_q, rflg_q, rier_q;
	logic [2:0]  txe_q, tier_q, hit_q, bg_hit_q;
	cfsc_fmode_e fm_q;
	cfsc_state_e st_q;
	logic        bg_full_q, rx_m_q, rx_s_q;
	logic [3:0]  run_q;
	logic [7:0]  grp_q;
	logic        awrdy_q, arrdy_q, bvalid_q, rvalid_q, busoff_done_q, fg_load_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        irq_wup_q, irq_err_q, irq_rx_q, irq_tx_q, tx_q, txen_q;
	cfsc_mode_e  mode_q;

	// Bus decode
	wire  [7:0]  wa      = 8'(s_axi_awaddr);
	wire  [7:0]  ra      = 8'(s_axi_araddr);
	wire         wr_fire = awrdy_q && s_axi_awvalid && s_axi_wvalid;
	wire         rd_fire = arrdy_q && s_axi_arvalid;
	wire         wr_b0   = wr_fire && s_axi_wstrb[0];
	wire         cfg_ok  = wr_b0 && soft_q && is_lock(wa);
	wire  [7:0]  wd      = s_axi_wdata[7:0];
	wire  [7:0]  rflg_clr = (wr_b0 && wa == `CFSC_OFF_RFLG) ? wd : 8'h00;
	wire  [2:0]  txe_clr  = (wr_b0 && wa == `CFSC_OFF_TFLG) ? wd[2:0] : 3'h0;

	// Mode selection
	wire         pdown   = cpu_stop || (cpu_wait && wstop_q);
	wire         asleep  = st_q == ST_SLEEP;
	wire         online  = (st_q == ST_RUN || st_q == ST_WAIT) && !soft_q && !pdown;
	wire         idle    = !rx_busy && (&txe_q);
	cfsc_mode_e  mode_d;
	assign mode_d = pdown ? MD_PDOWN : (soft_q ? MD_SOFT : (asleep ? MD_SLEEP : MD_NORMAL));

	// Identifier word laid out like a 32-bit pattern bank
	wire  [31:0] fw = rx_ide ? {rx_id[28:21], rx_id[20:18], rx_srr, 1'b1, rx_id[17:15], rx_id[14:7], rx_id[6:0],
		rx_rtr} : {rx_id[10:3], rx_id[2:0], rx_rtr, 1'b0, 3'h0, 16'h0};
	wire  [31:0] pat [2];
	wire  [31:0] msk [2];
	assign pat[0] = mif.words[31:0];
	assign pat[1] = mif.words[63:32];
	assign msk[0] = mif.words[95:64];
	assign msk[1] = mif.words[127:96];

	logic [1:0] h32;
	logic [3:0] h16;
	logic [7:0] h8;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_f32
			assign h32[g] = meq(fw, pat[g], msk[g]);
		end
		for (g = 0; g < 4; g++) begin : g_f16
			localparam int S = 31 - 16 * (g % 2);
			assign h16[g] = meq({fw[31:16], 16'h0}, {pat[g/2][S -: 16], 16'h0}, {msk[g/2][S -: 16], 16'h0});
		end
		for (g = 0; g < 8; g++) begin : g_f8
			localparam int S = 31 - 8 * (g % 4);
			assign h8[g] = meq({fw[31:24], 24'h0}, {pat[g/4][S -: 8], 24'h0}, {msk[g/4][S -: 8], 24'h0});
		end
	endgenerate

	wire  [7:0] hits = (fm_q == FM_32) ? {6'h0, h32} : (fm_q == FM_16) ? {4'h0, h16} :
		(fm_q == FM_8) ? h8 : 8'h00;
	wire  [2:0] enc     = first_hit(hits);
	wire        acc     = rx_eof && online && fm_q != FM_CLOSED && (|hits);
	wire        rxf_q_w = rflg_q[`CFSC_F_RXF];
	wire        copy_ev = !rxf_q_w && bg_full_q && online;
	wire        load_fg = copy_ev || (acc && !rxf_q_w && !bg_full_q);
	wire        to_bg   = acc && (rxf_q_w || bg_full_q) && (!bg_full_q || copy_ev);
	wire        ovr_ev  = acc && rxf_q_w && bg_full_q;

	// Flag sources: level conditions re-set every cycle, so a clear cannot win
	wire        rx_dom  = !rx_s_q;
	wire        wake_ev = asleep && rx_dom && rier_q[`CFSC_F_WUP];
	wire  [7:0] fset;
	assign fset[`CFSC_F_WUP]  = wake_ev;
	assign fset[`CFSC_F_RWRN] = rec_cnt >= `CFSC_WARN_LIM;
	assign fset[`CFSC_F_TWRN] = tec_cnt >= `CFSC_WARN_LIM;
	assign fset[`CFSC_F_RERR] = rec_cnt > `CFSC_PASS_LIM;
	assign fset[`CFSC_F_TERR] = tec_cnt > `CFSC_PASS_LIM;
	assign fset[`CFSC_F_BOFF] = tec_cnt > `CFSC_BOFF_LIM;
	assign fset[`CFSC_F_OVR]  = ovr_ev;
	assign fset[`CFSC_F_RXF]  = load_fg;
	wire  [7:0] rflg_d = (rflg_q & ~rflg_clr) | fset;
	wire  [2:0] txe_d  = (txe_q & ~txe_clr) | tx_done;

	// Recessive run counting, shared by resync and bus-off recovery
	wire        run_tick = bit_tick && !rx_dom;
	wire        run_done = run_tick && run_q == `CFSC_RUN_BITS - 4'h1;
	wire        clk_on   = !asleep && !soft_q && !pdown;
	wire        boff_cnt = fset[`CFSC_F_BOFF] && st_q == ST_RUN && online && run_done;
	wire        grp_last = grp_q == `CFSC_BOFF_GROUPS - 8'h01;

	// Read mux; error counters are only observed here
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0;
		case (ra)
			`CFSC_OFF_CTRL0:  rmux = {27'h0, rx_busy, asleep, wstop_q, sleep_request_bit_q, soft_q};
			`CFSC_OFF_CTRL1:  rmux = {24'h0, ctrl1_q};
			`CFSC_OFF_BT0:    rmux = {24'h0, bt0_q};
			`CFSC_OFF_BT1:    rmux = {24'h0, bt1_q};
			`CFSC_OFF_RFLG:   rmux = {24'h0, rflg_q};
			`CFSC_OFF_RIER:   rmux = {24'h0, rier_q};
			`CFSC_OFF_TFLG:   rmux = {29'h0, txe_q};
			`CFSC_OFF_TIER:   rmux = {29'h0, tier_q};
			`CFSC_OFF_ACC:    rmux = {26'h0, fm_q, 1'b0, hit_q};
			`CFSC_OFF_ERRCNT: rmux = {7'h0, tec_cnt, 7'h0, rec_cnt};
			default:          rmux = ((ra & `CFSC_FILT_MASK) == `CFSC_OFF_FILT) ? mif.words[32*ra[3:2] +: 32] : 32'h0;
		endcase
	end

	assign mif.we    = wr_fire && soft_q && (wa & `CFSC_FILT_MASK) == `CFSC_OFF_FILT;
	assign mif.waddr = wa[3:2];
	assign mif.wdata = s_axi_wdata;
	assign mif.wstrb = s_axi_wstrb;

	// AXI handshakes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awrdy_q  <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= `CFSC_RESP_OKAY;
			arrdy_q  <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q  <= `CFSC_RESP_OKAY;
			rdata_q  <= 32'h0;
		end else begin
			awrdy_q <= s_axi_awvalid && s_axi_wvalid && !awrdy_q && !bvalid_q;
			arrdy_q <= s_axi_arvalid && !arrdy_q && !rvalid_q;
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= is_known(wa) ? `CFSC_RESP_OKAY : `CFSC_RESP_DECERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rresp_q  <= is_known(ra) ? `CFSC_RESP_OKAY : `CFSC_RESP_DECERR;
				rdata_q  <= rmux;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_q  <= `CFSC_RST_SOFT;
			sleep_request_bit_q <= 1'b0;
			wstop_q <= 1'b0;
			ctrl1_q <= 8'h00;
			bt0_q   <= 8'h00;
			bt1_q   <= 8'h00;
			fm_q    <= FM_32;
			rier_q  <= 8'h00;
			tier_q  <= 3'h0;
		end else if (wr_b0) begin
			if (wa == `CFSC_OFF_CTRL0) begin
				soft_q  <= wd[`CFSC_C0_SOFT];
				wstop_q <= wd[`CFSC_C0_WSTOP];
				sleep_request_bit_q <= wd[`CFSC_C0_SLEEP_REQUEST_BIT] || (sleep_request_bit_q && !asleep);
			end
			if (cfg_ok && wa == `CFSC_OFF_CTRL1) ctrl1_q <= wd;
			if (cfg_ok && wa == `CFSC_OFF_BT0) bt0_q <= wd;
			if (cfg_ok && wa == `CFSC_OFF_BT1) bt1_q <= wd;
			if (cfg_ok && wa == `CFSC_OFF_ACC) fm_q <= cfsc_fmode_e'(wd[`CFSC_AC_MODE_HI:`CFSC_AC_MODE_LO]);
			if (wa == `CFSC_OFF_RIER) rier_q <= wd;
			if (wa == `CFSC_OFF_TIER) tier_q <= wd[2:0];
		end
	end

	// Flags, receive buffers and hit index
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rflg_q    <= 8'h00;
			txe_q     <= `CFSC_RST_TXE;
			bg_full_q <= 1'b0;
			bg_hit_q  <= 3'h0;
			hit_q     <= 3'h0;
			fg_load_q <= 1'b0;
		end else begin
			rflg_q    <= rflg_d;
			txe_q     <= txe_d;
			bg_full_q <= to_bg || (bg_full_q && !copy_ev);
			fg_load_q <= load_fg;
			if (to_bg) bg_hit_q <= enc;
			if (copy_ev) hit_q <= bg_hit_q;
			else if (load_fg) hit_q <= enc;
		end
	end

	// Sleep sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_RUN;
		end else if (soft_q) begin
			st_q <= ST_RESYNC;
		end else begin
			case (st_q)
				ST_RUN:    if (sleep_request_bit_q) st_q <= idle ? ST_SLEEP : ST_WAIT;
				ST_WAIT:   if (idle) st_q <= ST_SLEEP;
				ST_SLEEP:  if (rx_dom || !sleep_request_bit_q) st_q <= ST_RESYNC;
				ST_RESYNC: if (run_done) st_q <= ST_RUN;
				default:   st_q <= ST_RUN;
			endcase
		end
	end

	// Pin sync, recessive runs and bus-off recovery
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_m_q        <= 1'b1;
			rx_s_q        <= 1'b1;
			run_q         <= 4'h0;
			grp_q         <= 8'h00;
			busoff_done_q <= 1'b0;
		end else begin
			rx_m_q        <= can_rx;
			rx_s_q        <= rx_m_q;
			busoff_done_q <= boff_cnt && grp_last;
			if (!clk_on || (bit_tick && rx_dom) || run_done) run_q <= 4'h0;
			else if (run_tick) run_q <= run_q + 4'h1;
			if (!fset[`CFSC_F_BOFF]) grp_q <= 8'h00;
			else if (boff_cnt) grp_q <= grp_last ? 8'h00 : grp_q + 8'h01;
		end
	end

	// Registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_wup_q <= 1'b0;
			irq_err_q <= 1'b0;
			irq_rx_q  <= 1'b0;
			irq_tx_q  <= 1'b0;
			tx_q      <= 1'b1;
			txen_q    <= 1'b0;
			mode_q    <= MD_NORMAL;
		end else begin
			irq_wup_q <= rflg_q[`CFSC_F_WUP] && rier_q[`CFSC_F_WUP];
			irq_err_q <= |(rflg_q[`CFSC_F_RWRN:`CFSC_F_OVR] & rier_q[`CFSC_F_RWRN:`CFSC_F_OVR]);
			irq_rx_q  <= rflg_q[`CFSC_F_RXF] && rier_q[`CFSC_F_RXF];
			irq_tx_q  <= |(txe_q & tier_q);
			tx_q      <= (online && !cpu_stop) ? core_tx : 1'b1;
			txen_q    <= online;
			mode_q    <= mode_d;
		end
	end

	assign s_axi_awready    = awrdy_q;
	assign s_axi_wready     = awrdy_q;
	assign s_axi_bvalid     = bvalid_q;
	assign s_axi_bresp      = bresp_q;
	assign s_axi_arready    = arrdy_q;
	assign s_axi_rvalid     = rvalid_q;
	assign s_axi_rresp      = rresp_q;
	assign s_axi_rdata      = rdata_q;
	assign can_tx_out       = tx_q;
	assign irq_wakeup       = irq_wup_q;
	assign irq_error        = irq_err_q;
	assign irq_rx           = irq_rx_q;
	assign irq_tx           = irq_tx_q;
	assign fg_load          = fg_load_q;
	assign filter_hit_index = hit_q;
	assign tx_empty_flag    = txe_q;
	assign tx_enable        = txen_q;
	assign busoff_done      = busoff_done_q;
	assign mode             = mode_q;

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	stop_recessive_a: assert property (cpu_stop |=> can_tx_out) else $error("tx not recessive in stop");
	cfg_lock_a: assert property (wr_fire && !soft_q |=> $stable({ctrl1_q, bt0_q, bt1_q, fm_q}) &&
		$stable(mif.words)) else $error("locked register changed outside soft reset");
	closed_filter_a: assert property (fm_q == FM_CLOSED |-> !acc) else $error("closed filter accepted");
	rx_full_a: assert property (load_fg |=> rflg_q[`CFSC_F_RXF] && fg_load)
		else $error("full flag not set after load");
	hit_index_a: assert property (load_fg && !copy_ev |=> filter_hit_index == $past(enc))
		else $error("hit index wrong");
	warn_flag_a: assert property (rec_cnt >= `CFSC_WARN_LIM |=> rflg_q[`CFSC_F_RWRN][*2])
		else $error("receive warning flag lost");
	passive_flag_a: assert property (tec_cnt > `CFSC_PASS_LIM |=> rflg_q[`CFSC_F_TERR])
		else $error("transmit passive flag not set");
	busoff_flag_a: assert property (tec_cnt > `CFSC_BOFF_LIM |=> rflg_q[`CFSC_F_BOFF] ##1 irq_error ||
		!rier_q[`CFSC_F_BOFF]) else $error("bus-off flag or interrupt missing");
	tx_irq_a: assert property (|(txe_q & tier_q) |=> irq_tx) else $error("transmit interrupt missing");
	wake_only_a: assert property ($rose(rflg_q[`CFSC_F_WUP]) |-> $past(asleep)) else $error("wake outside sleep");
	sleep_idle_a: assert property ($rose(asleep) |-> $past(idle)) else $error("slept while busy");
	overrun_a: assert property (ovr_ev |=> rflg_q[`CFSC_F_OVR] && bg_full_q) else $error("overrun lost");

	accept_c: cover property (load_fg ##[1:20] copy_ev);
	overrun_c: cover property (ovr_ev);
	sleep_wake_c: cover property ($rose(asleep) ##[1:200] st_q == ST_RUN);
	busoff_c: cover property (busoff_done);
endmodule : cfsc_top

// File: testbench/cfsc_engine_model.sv
// Behavioural protocol engine and bus node standing behind the control block
`timescale 1ns/1ps
module cfsc_engine_model #(
	parameter int BIT_CYC = 4
) (
	// Clock
	input  wire logic   aclk,
	// Engine status
	output logic        bit_tick = 1'b0,
	output logic        rx_eof   = 1'b0,
	output logic [28:0] rx_id    = 29'h0,
	output logic        rx_ide   = 1'b0,
	output logic        rx_rtr   = 1'b0,
	output logic        rx_srr   = 1'b0,
	output logic        rx_busy  = 1'b0,
	output logic [2:0]  tx_done  = 3'h0,
	output logic [8:0]  rec_cnt  = 9'h0,
	output logic [8:0]  tec_cnt  = 9'h0,
	// Bus pin, 1 is recessive
	output logic        can_rx   = 1'b1
);
	int cyc_q = 0;
	always @(posedge aclk) begin
		cyc_q    <= (cyc_q == BIT_CYC - 1) ? 0 : cyc_q + 1;
		bit_tick <= (cyc_q == BIT_CYC - 1);
	end
	// Busy for a while, then end of frame with identifier fields {id, ide, rtr, srr}
	task automatic frame(input logic [31:0] f);
		rx_busy <= 1'b1;
		repeat (12) @(posedge aclk);
		{rx_id, rx_ide, rx_rtr, rx_srr} <= f;
		rx_eof <= 1'b1;
		@(posedge aclk);
		rx_eof  <= 1'b0;
		rx_busy <= 1'b0;
		// Fields are not valid outside the pulse, so never leave the last value
		{rx_id, rx_ide, rx_rtr, rx_srr} <= ~f;
		@(posedge aclk);
	endtask : frame
	task automatic done(input logic [2:0] b);
		tx_done <= b;
		@(posedge aclk);
		tx_done <= 3'h0;
	endtask : done
	task automatic busy(input logic b);
		rx_busy <= b;
	endtask : busy
	task automatic bus(input logic b);
		can_rx <= b;
	endtask : bus
	task automatic counts(input logic [8:0] r, input logic [8:0] t);
		rec_cnt <= r;
		tec_cnt <= t;
	endtask : counts
endmodule : cfsc_engine_model

// File: testbench/test_can_filter_irq_sleep_ctrl.sv
// Self-checking bench of the CAN filter, flag and low-power control block
`timescale 1ns/1ps
`include "cfsc_defs.svh"
`define CK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module test_can_filter_irq_sleep_ctrl;
	import cfsc_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        bit_tick, core_tx, rx_eof, rx_ide, rx_rtr, rx_srr, rx_busy, cpu_stop, cpu_wait;
	logic        can_rx, can_tx_out, irq_wakeup, irq_error, irq_rx, irq_tx, fg_load, tx_enable, busoff_done;
	logic [28:0] rx_id;
	logic [2:0]  tx_done, filter_hit_index, tx_empty_flag;
	logic [8:0]  rec_cnt, tec_cnt;
	cfsc_mode_e  mode;
	int          miscompares = 0, samples_checked = 0, loads = 0;
	always #4 aclk = ~aclk;
	always @(posedge aclk) if (fg_load === 1'b1) loads++;
	cfsc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_tick, .core_tx, .rx_eof,
		.rx_id, .rx_ide, .rx_rtr, .rx_srr, .rx_busy, .tx_done, .rec_cnt, .tec_cnt, .cpu_stop, .cpu_wait, .can_rx,
		.can_tx_out, .irq_wakeup, .irq_error, .irq_rx, .irq_tx, .fg_load, .filter_hit_index, .tx_empty_flag,
		.tx_enable, .busoff_done, .mode);
	cfsc_engine_model eng_u (.aclk, .bit_tick, .rx_eof, .rx_id, .rx_ide, .rx_rtr, .rx_srr, .rx_busy, .tx_done,
		.rec_cnt, .tec_cnt, .can_rx);
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		rsp  = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// Program filter mode, patterns and masks under soft reset, then go back online
	task automatic cfg(input logic [1:0] m, input logic [63:0] p, input logic [63:0] k);
		wr(`CFSC_OFF_CTRL0, 32'h1);
		wr(`CFSC_OFF_ACC, {26'h0, m, 4'h0});
		wr(`CFSC_OFF_FILT, p[63:32]);
		wr(8'h34, p[31:0]);
		wr(8'h38, k[63:32]);
		wr(8'h3c, k[31:0]);
		wr(`CFSC_OFF_CTRL0, 32'h0);
		for (int i = 0; i < 300 && tx_enable !== 1'b1; i++) @(posedge aclk);
		wr(`CFSC_OFF_ACC, {26'h0, ~m, 4'h0});
		rd(`CFSC_OFF_ACC);
		`CK("filter mode", m, rdat[5:4])
	endtask : cfg
	task automatic t_reset;
		`CK("mode", MD_SOFT, mode)
		`CK("tx pin", 1'b1, can_tx_out)
		`CK("tx empty", 3'h7, tx_empty_flag)
		rd(`CFSC_OFF_CTRL0);
		`CK("soft bit", 1'b1, rdat[0])
		rd(8'h28);
		`CK("unmapped", `CFSC_RESP_DECERR, rsp)
	endtask : t_reset
	// Open modes: only the last filter, all filters, or filter 0 by its mask alone; closed mode: only the last filter
	task automatic t_filter;
		int n;
		int l0;
		logic [63:0] p;
		for (int m = 3; m >= 0; m--) begin
			n = 2 << m;
			for (int c = 0; c < ((m == 3) ? 1 : 3); c++) begin
				p = (64'h1 << (64 / n)) - 64'h1;
				cfg(m[1:0], (c == 1) ? ~64'h0 : (c == 2) ? 64'h0 : p, (c == 2) ? ~(~64'h0 >> (64 / n)) : 64'h0);
				l0 = loads;
				eng_u.frame({29'h1fffffff, 3'h7});
				cyc(3);
				rd(`CFSC_OFF_RFLG);
				`CK("rx full", (m != 3), rdat[0])
				`CK("loads", (m != 3) ? 1 : 0, loads - l0)
				if (m != 3) `CK("hit", (c == 0) ? 3'(n - 1) : 3'h0, filter_hit_index)
				wr(`CFSC_OFF_RFLG, 32'h1);
			end
		end
	endtask : t_filter
	task automatic t_irq;
		wr(`CFSC_OFF_TIER, 32'h1);
		wr(`CFSC_OFF_RIER, 32'h3);
		cyc(2);
		`CK("tx irq", 1'b1, irq_tx)
		wr(`CFSC_OFF_TFLG, 32'h1);
		cyc(2);
		`CK("tx empty", 3'h6, tx_empty_flag)
		`CK("tx irq off", 1'b0, irq_tx)
		eng_u.done(3'h1);
		cyc(2);
		`CK("tx irq back", 1'b1, irq_tx)
		repeat (3) eng_u.frame({29'h0000155, 3'h2});
		cyc(3);
		`CK("rx irq", 1'b1, irq_rx)
		`CK("err irq", 1'b1, irq_error)
		rd(`CFSC_OFF_RFLG);
		`CK("overrun", 1'b1, rdat[1])
		s_axi_wstrb <= 4'he;
		wr(`CFSC_OFF_RFLG, 32'h2);
		`CK("lane0 off", 1'b1, irq_error)
		s_axi_wstrb <= 4'hf;
		wr(`CFSC_OFF_RFLG, 32'h2);
		cyc(2);
		`CK("err irq off", 1'b0, irq_error)
	endtask : t_irq
	task automatic t_sleep;
		int l0;
		core_tx <= 1'b0;
		wr(`CFSC_OFF_RIER, 32'h80);
		eng_u.bus(1'b0);
		cyc(8);
		eng_u.bus(1'b1);
		cyc(4);
		`CK("wake awake", 1'b0, irq_wakeup)
		`CK("tx pin online", 1'b0, can_tx_out)
		eng_u.busy(1'b1);
		wr(`CFSC_OFF_CTRL0, 32'h2);
		cyc(20);
		rd(`CFSC_OFF_CTRL0);
		`CK("ack busy", 1'b0, rdat[3])
		wr(`CFSC_OFF_CTRL0, 32'h0);
		rd(`CFSC_OFF_CTRL0);
		`CK("request kept", 1'b1, rdat[1])
		eng_u.busy(1'b0);
		for (int i = 0; i < 100 && mode !== MD_SLEEP; i++) @(posedge aclk);
		`CK("sleep mode", MD_SLEEP, mode)
		`CK("tx pin sleep", 1'b1, can_tx_out)
		rd(`CFSC_OFF_CTRL0);
		`CK("ack", 1'b1, rdat[3])
		l0 = loads;
		eng_u.frame({29'h1fffffff, 3'h7});
		cyc(3);
		`CK("no copy", 0, loads - l0)
		eng_u.bus(1'b0);
		for (int i = 0; i < 50 && irq_wakeup !== 1'b1; i++) @(posedge aclk);
		`CK("wake irq", 1'b1, irq_wakeup)
		`CK("resync", 1'b0, tx_enable)
		eng_u.bus(1'b1);
		for (int i = 0; i < 300 && mode !== MD_SLEEP; i++) @(posedge aclk);
		// Request is dropped only once the acknowledge was seen
		wr(`CFSC_OFF_CTRL0, 32'h0);
		for (int i = 0; i < 300 && tx_enable !== 1'b1; i++) @(posedge aclk);
		`CK("normal", MD_NORMAL, mode)
		wr(`CFSC_OFF_RFLG, 32'h80);
		cyc(2);
		`CK("wake clr", 1'b0, irq_wakeup)
	endtask : t_sleep
	task automatic t_pdown;
		cpu_stop <= 1'b1;
		cyc(3);
		`CK("stop mode", MD_PDOWN, mode)
		`CK("tx pin stop", 1'b1, can_tx_out)
		cpu_stop <= 1'b0;
		cyc(3);
		wr(`CFSC_OFF_CTRL0, 32'h4);
		cpu_wait <= 1'b1;
		cyc(3);
		`CK("wait stop", MD_PDOWN, mode)
		cpu_wait <= 1'b0;
		cyc(3);
		wr(`CFSC_OFF_CTRL0, 32'h0);
		cpu_wait <= 1'b1;
		cyc(3);
		`CK("wait run", MD_NORMAL, mode)
		cpu_wait <= 1'b0;
		core_tx  <= 1'b1;
	endtask : t_pdown
	// Counter boundaries {rec, tec, expected error flags}
	logic [25:0] tab [8] = '{{9'd95, 9'd0, 8'h00}, {9'd96, 9'd0, 8'h40}, {9'd127, 9'd0, 8'h40},
		{9'd128, 9'd0, 8'h50}, {9'd0, 9'd95, 8'h00}, {9'd0, 9'd96, 8'h20}, {9'd0, 9'd128, 8'h28},
		{9'd0, 9'd256, 8'h2c}};
	task automatic t_err;
		wr(`CFSC_OFF_RIER, 32'h7c);
		foreach (tab[i]) begin
			eng_u.counts(tab[i][25:17], tab[i][16:8]);
			cyc(3);
			wr(`CFSC_OFF_RFLG, 32'h7c);
			rd(`CFSC_OFF_RFLG);
			`CK("err flags", tab[i][7:0], rdat[7:0] & 8'h7c)
			`CK("err irq", (tab[i][7:0] != 8'h0), irq_error)
			eng_u.counts(9'h0, 9'h0);
			cyc(3);
			wr(`CFSC_OFF_RFLG, 32'h7c);
			rd(`CFSC_OFF_RFLG);
			`CK("err clr", 8'h0, rdat[7:0] & 8'h7c)
		end
		eng_u.counts(9'h0, 9'h100);
		for (int i = 0; i < 6000 && busoff_done !== 1'b1; i++) @(posedge aclk);
		`CK("busoff done", 1'b1, busoff_done)
		eng_u.counts(9'h5, 9'h9);
		wr(`CFSC_OFF_ERRCNT, 32'hffffffff);
		rd(`CFSC_OFF_ERRCNT);
		`CK("counters", {7'h0, 9'h9, 7'h0, 9'h5}, rdat)
	endtask : t_err
	task automatic summarize;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	initial begin
		{aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, cpu_stop, cpu_wait} = '0;
		s_axi_wstrb = 4'hf;
		core_tx     = 1'b1;
		cyc(8);
		aresetn <= 1'b1;
		cyc(2);
		t_reset;
		t_filter;
		t_irq;
		t_sleep;
		t_pdown;
		t_err;
		summarize;
	end
	initial begin
		#400000;
		miscompares++;
		summarize;
	end
endmodule : test_can_filter_irq_sleep_ctrl
